// [stb_regs.vh]
// Register map, field positions and codes of the split byte timer
`ifndef STB_REGS_VH
`define STB_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define STB_ADR_CTRL 8'h01
`define STB_ADR_IRQ_EN 8'h06
`define STB_ADR_CTRLG_CLR 8'h08
`define STB_ADR_CTRLG_SET 8'h09
`define STB_ADR_BV_CLR 8'h0a
`define STB_ADR_BV_SET 8'h0b
`define STB_ADR_FLAGS 8'h0c
`define STB_ADR_LOW_COUNT_BYTE 8'h20
`define STB_ADR_LOW_PERIOD_BYTE 8'h26
`define STB_ADR_LOW_PERIOD_BUFFER_BYTE 8'h37
`define STB_ADR_LCC_BASE 8'h28
`define STB_ADR_HCC_BASE 8'h29
`define STB_ADR_LCCBUF_BASE 8'h38
`define STB_ADR_HCCBUF_BASE 8'h39

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define STB_CTRL_RUN 3
`define STB_CTRL_CAPT 4
`define STB_G_DIR 0
`define STB_G_LOCK 1
`define STB_G_CMD_LSB 2
`define STB_FLAG_WRAP 0
`define STB_FLAG_TRIG 2
`define STB_FLAG_MATCH_LSB 4
`define STB_BV_PER 0

// ----------------------------------------------------------------
// Codes and reset values
// ----------------------------------------------------------------
`define STB_WG_DS_BOT 3'h5
`define STB_WG_DS_TOP 3'h6
`define STB_CMD_UPDATE 2'h1
`define STB_CMD_RESTART 2'h2
`define STB_CMD_RESET 2'h3
`define STB_BYTE_RST 8'h00

`endif

// [stb_mem.v]
// Small register-read memory holding the high channel compare and buffer bytes
`include "stb_regs.vh"
`default_nettype none

module stb_mem (
  input wire clk_i,
  input wire srst_i,
  input wire we_i,
  input wire [2:0] waddr_i,
  input wire [7:0] wdata_i,
  input wire [2:0] raddr_i,
  input wire sel_local_i,
  input wire [7:0] local_i,
  output reg [7:0] rdata_ff
);

  reg [7:0] mem_ff [0:7];
  integer i;

  always @(posedge clk_i) begin
    if (srst_i) begin
      for (i = 0; i < 8; i = i + 1) begin
        mem_ff[i] <= `STB_BYTE_RST;
      end
    end else if (we_i) begin
      mem_ff[waddr_i] <= wdata_i;
    end
  end

  // Local registers share this output flop so read data always leave a flop
  always @(posedge clk_i) begin
    if (srst_i) begin
      rdata_ff <= `STB_BYTE_RST;
    end else begin
      rdata_ff <= sel_local_i ? local_i : mem_ff[raddr_i];
    end
  end

endmodule // stb_mem

`default_nettype wire

// [stb_cnt.v]
// Low byte counter with single and dual slope direction handling
`default_nettype none

module stb_cnt (
  input wire clk_i,
  input wire srst_i,
  input wire run_i,
  input wire dual_i,
  input wire [7:0] per_i,
  input wire load_i,
  input wire [7:0] load_val_i,
  input wire restart_i,
  input wire dir_wr_i,
  input wire dir_val_i,
  output reg [7:0] cnt_ff,
  output reg dir_ff,
  output reg top_ff,
  output reg bot_ff
);

  reg [7:0] nxt_cnt;
  reg nxt_dir;
  wire at_top;
  wire at_bot;

  assign at_top = run_i && !dir_ff && (cnt_ff == per_i);
  assign at_bot = run_i && dir_ff && (cnt_ff == 8'h00);

  always @* begin
    nxt_cnt = cnt_ff;
    nxt_dir = dir_ff;
    if (restart_i) begin
      nxt_cnt = 8'h00;
      nxt_dir = 1'b0;
    end else begin
      if (run_i) begin
        if (!dir_ff) begin
          if (at_top) begin
            nxt_cnt = dual_i ? cnt_ff - 8'h01 : 8'h00;
            nxt_dir = dual_i;
          end else begin
            nxt_cnt = cnt_ff + 8'h01;
          end
        end else begin
          if (at_bot) begin
            nxt_cnt = dual_i ? cnt_ff + 8'h01 : per_i;
            nxt_dir = !dual_i;
          end else begin
            nxt_cnt = cnt_ff - 8'h01;
          end
        end
      end
      // Software writes win over counting in the same cycle
      if (load_i) begin
        nxt_cnt = load_val_i;
      end
      if (dir_wr_i) begin
        nxt_dir = dir_val_i;
      end
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      cnt_ff <= 8'h00;
      dir_ff <= 1'b0;
      top_ff <= 1'b0;
      bot_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      dir_ff <= nxt_dir;
      top_ff <= at_top && !restart_i && !load_i;
      bot_ff <= at_bot && !restart_i && !load_i;
    end
  end

endmodule // stb_cnt

`default_nettype wire

// [stb_top.v]
// Low byte half of a split byte timer: counter, period, channels, flags
//
// Functional notes
// - Wrap flag on top or bottom per mode
// - Vector execution leaves wrap flag set
// - Writing one clears wrap flag; zero ignored
// - Wrap flag drives transfer request
// - Transfer write to count/period/buffer clears flag
// - Low count byte, read/write, resets zero
// - Low period byte, read/write, resets zero
// - Low channel compare bytes, read/write, reset zero
// - High channel compare bytes, read/write, reset zero
// - Low period buffer byte, read/write, resets zero
// - Low channel buffer bytes, read/write, reset zero
// - High channel buffer bytes, read/write, reset zero; never transferred
// - Period buffer valid set on write, cleared on update
// - Update lock blocks buffer transfers outside capture
// - Compare equality sets match flag while running outside capture
`include "stb_regs.vh"
`default_nettype none

module stb_top (
  input wire clk_i,
  input wire srst_i,
  input wire [7:0] addr_i,
  input wire [7:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire dma_i,
  input wire [3:0] match_ack_i,
  input wire wrap_ack_i,
  input wire trig_i,
  output wire [7:0] rdata_o,
  output reg irq_o,
  output reg dma_req_o
);

  // ----------------------------------------------------------------
  // Address decode helpers
  // ----------------------------------------------------------------
  function is_lcc;
    input [7:0] a;
    begin
      is_lcc = (a[7:4] == 4'h2) && a[3] && !a[0];
    end
  endfunction

  function is_lccbuf;
    input [7:0] a;
    begin
      is_lccbuf = (a[7:4] == 4'h3) && a[3] && !a[0];
    end
  endfunction

  function is_high;
    input [7:0] a;
    begin
      is_high = ((a[7:4] == 4'h2) || (a[7:4] == 4'h3)) && a[3] && a[0];
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg [7:0] ctrl_ff;
  reg [7:0] irq_en_ff;
  reg lock_ff;
  reg [7:0] flags_ff;
  reg [7:0] per_ff;
  reg [7:0] perbuf_ff;
  reg [7:0] lcc_ff [0:3];
  reg [7:0] lccbuf_ff [0:3];
  reg [4:0] bv_ff;
  reg [2:0] trig_sync_ff;
  reg [7:0] nxt_flags;
  reg [4:0] nxt_bv;
  reg [7:0] local_rd;
  integer n;
  // Own index for the combinational flag loop so no variable has two drivers
  integer k;

  wire [7:0] cnt;
  wire dir;
  wire top_evt;
  wire bot_evt;
  wire [2:0] wg_sel;
  wire dual;
  wire capt;
  wire wr_low_count_byte;
  wire wr_low_period_byte;
  wire wr_low_period_buffer_byte;
  wire wr_gclr;
  wire wr_gset;
  wire [1:0] cmd;
  wire trig_evt;
  wire restart;
  wire upd_cond;
  wire upd_go;
  wire wrap_evt;
  wire [1:0] ch;
  wire run;
  wire wr_ctrl;
  wire wr_irq_en;
  wire wr_bv_clr;
  wire wr_bv_set;
  wire wr_flags;
  wire wr_lcc;
  wire wr_lccbuf;
  wire dma_clr;

  assign wg_sel = ctrl_ff[2:0];
  assign dual = wg_sel[2];
  assign capt = ctrl_ff[`STB_CTRL_CAPT];
  assign ch = addr_i[2:1];
  assign wr_low_count_byte = wr_i && (addr_i == `STB_ADR_LOW_COUNT_BYTE);
  assign wr_low_period_byte = wr_i && (addr_i == `STB_ADR_LOW_PERIOD_BYTE);
  assign wr_low_period_buffer_byte = wr_i && (addr_i == `STB_ADR_LOW_PERIOD_BUFFER_BYTE);
  assign wr_gclr = wr_i && (addr_i == `STB_ADR_CTRLG_CLR);
  assign wr_gset = wr_i && (addr_i == `STB_ADR_CTRLG_SET);
  assign cmd = (wr_gclr || wr_gset) ? wdata_i[`STB_G_CMD_LSB+1:`STB_G_CMD_LSB] : 2'h0;
  assign run = ctrl_ff[`STB_CTRL_RUN];
  assign wr_ctrl = wr_i && (addr_i == `STB_ADR_CTRL);
  assign wr_irq_en = wr_i && (addr_i == `STB_ADR_IRQ_EN);
  assign wr_bv_clr = wr_i && (addr_i == `STB_ADR_BV_CLR);
  assign wr_bv_set = wr_i && (addr_i == `STB_ADR_BV_SET);
  assign wr_flags = wr_i && (addr_i == `STB_ADR_FLAGS);
  assign wr_lcc = wr_i && is_lcc(addr_i);
  assign wr_lccbuf = wr_i && is_lccbuf(addr_i);
  // Only transfer engine writes to these bytes withdraw the request; plain software writes to them do not
  assign dma_clr = dma_i && (wr_low_count_byte || wr_low_period_byte || wr_low_period_buffer_byte);

  // ----------------------------------------------------------------
  // Trigger restart pin
  // ----------------------------------------------------------------
  // Second and third stages feed the edge detector; the first stays clean
  always @(posedge clk_i) begin
    if (srst_i) begin
      trig_sync_ff <= 3'h0;
    end else begin
      trig_sync_ff <= {trig_sync_ff[1:0], trig_i};
    end
  end

  assign trig_evt = trig_sync_ff[1] && !trig_sync_ff[2];
  // A hard reset command only acts while the counter is stopped
  assign restart = trig_evt || (cmd == `STB_CMD_RESTART) ||
                   ((cmd == `STB_CMD_RESET) && !run);

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  stb_cnt u_cnt (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .run_i(run),
    .dual_i(dual),
    .per_i(per_ff),
    .load_i(wr_low_count_byte),
    .load_val_i(wdata_i),
    .restart_i(restart),
    .dir_wr_i((wr_gclr || wr_gset) && wdata_i[`STB_G_DIR]),
    .dir_val_i(wr_gset),
    .cnt_ff(cnt),
    .dir_ff(dir),
    .top_ff(top_evt),
    .bot_ff(bot_evt)
  );

  // Single slope wraps where it turns; dual slope picks its edge by mode
  assign wrap_evt = !dual ? (top_evt || bot_evt) :
                    (wg_sel == `STB_WG_DS_BOT) ? bot_evt :
                    (wg_sel == `STB_WG_DS_TOP) ? top_evt :
                    (top_evt || bot_evt);
  assign upd_cond = (dual ? bot_evt : (top_evt || bot_evt)) ||
                    (cmd == `STB_CMD_UPDATE);
  // Lock has no effect in capture operation
  assign upd_go = upd_cond && (!lock_ff || capt);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (srst_i) begin
      ctrl_ff <= 8'h00;
      irq_en_ff <= 8'h00;
      lock_ff <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= {3'h0, wdata_i[4:0]};
      end
      if (wr_irq_en) begin
        irq_en_ff <= wdata_i & 8'hf5;
      end
      if (wr_gset && wdata_i[`STB_G_LOCK]) begin
        lock_ff <= 1'b1;
      end else if (wr_gclr && wdata_i[`STB_G_LOCK]) begin
        lock_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Period, channel and buffer bytes
  // ----------------------------------------------------------------
  always @* begin
    nxt_bv = bv_ff;
    if (upd_go) begin
      nxt_bv = 5'h00;
    end
    if (wr_bv_clr) begin
      nxt_bv = nxt_bv & ~wdata_i[4:0];
    end
    if (wr_bv_set) begin
      nxt_bv = nxt_bv | wdata_i[4:0];
    end
    // New buffer data sets valid and beats a same-cycle clear
    if (wr_low_period_buffer_byte) begin
      nxt_bv[`STB_BV_PER] = 1'b1;
    end
    // Widen before adding so channel D lands on bit 4, not on the period bit
    if (wr_lccbuf) begin
      nxt_bv[{1'b0, ch} + 3'd1] = 1'b1;
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      per_ff <= `STB_BYTE_RST;
      perbuf_ff <= `STB_BYTE_RST;
      bv_ff <= 5'h00;
      for (n = 0; n < 4; n = n + 1) begin
        lcc_ff[n] <= `STB_BYTE_RST;
        lccbuf_ff[n] <= `STB_BYTE_RST;
      end
    end else begin
      bv_ff <= nxt_bv;
      if (upd_go && bv_ff[`STB_BV_PER]) begin
        per_ff <= perbuf_ff;
      end
      if (wr_low_period_byte) begin
        per_ff <= wdata_i;
      end
      if (wr_low_period_buffer_byte) begin
        perbuf_ff <= wdata_i;
      end
      for (n = 0; n < 4; n = n + 1) begin
        if (upd_go && bv_ff[n+1]) begin
          lcc_ff[n] <= lccbuf_ff[n];
        end
      end
      if (wr_lcc) begin
        lcc_ff[ch] <= wdata_i;
      end
      if (wr_lccbuf) begin
        lccbuf_ff[ch] <= wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags, interrupt and transfer request
  // ----------------------------------------------------------------
  always @* begin
    nxt_flags = flags_ff;
    // Vector execution clears match flags only; the wrap flag stays
    nxt_flags[7:4] = flags_ff[7:4] & ~match_ack_i;
    if (wrap_ack_i) begin
      nxt_flags[`STB_FLAG_WRAP] = flags_ff[`STB_FLAG_WRAP];
    end
    if (wr_flags) begin
      nxt_flags = nxt_flags & ~(wdata_i & 8'hf5);
    end
    if (dma_clr) begin
      nxt_flags[`STB_FLAG_WRAP] = 1'b0;
    end
    // Hardware events win over any clear in the same cycle
    if (wrap_evt) begin
      nxt_flags[`STB_FLAG_WRAP] = 1'b1;
    end
    if (trig_evt) begin
      nxt_flags[`STB_FLAG_TRIG] = 1'b1;
    end
    for (k = 0; k < 4; k = k + 1) begin
      if (!capt && run && (cnt == lcc_ff[k])) begin
        nxt_flags[`STB_FLAG_MATCH_LSB + k] = 1'b1;
      end
    end
  end

  always @(posedge clk_i) begin
    if (srst_i) begin
      flags_ff <= 8'h00;
      irq_o <= 1'b0;
      dma_req_o <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      irq_o <= |(nxt_flags & irq_en_ff);
      dma_req_o <= nxt_flags[`STB_FLAG_WRAP];
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always @* begin
    local_rd = 8'h00;
    case (addr_i)
      `STB_ADR_CTRL: local_rd = ctrl_ff;
      `STB_ADR_IRQ_EN: local_rd = irq_en_ff;
      `STB_ADR_CTRLG_CLR, `STB_ADR_CTRLG_SET: local_rd = {6'h00, lock_ff, dir};
      `STB_ADR_BV_CLR, `STB_ADR_BV_SET: local_rd = {3'h0, bv_ff};
      `STB_ADR_FLAGS: local_rd = flags_ff;
      `STB_ADR_LOW_COUNT_BYTE: local_rd = cnt;
      `STB_ADR_LOW_PERIOD_BYTE: local_rd = per_ff;
      `STB_ADR_LOW_PERIOD_BUFFER_BYTE: local_rd = perbuf_ff;
      default: begin
        if (is_lcc(addr_i)) begin
          local_rd = lcc_ff[ch];
        end else if (is_lccbuf(addr_i)) begin
          local_rd = lccbuf_ff[ch];
        end
      end
    endcase
  end

  stb_mem u_mem (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .we_i(wr_i && is_high(addr_i)),
    .waddr_i({addr_i[4], addr_i[2:1]}),
    .wdata_i(wdata_i),
    .raddr_i({addr_i[4], addr_i[2:1]}),
    .sel_local_i(!(rd_i && is_high(addr_i))),
    .local_i(rd_i ? local_rd : 8'h00),
    .rdata_ff(rdata_o)
  );

endmodule // stb_top

`default_nettype wire

// [stb_top_props.sv]
// Port level assertions for the split byte timer register block
`include "stb_regs.vh"
`default_nettype none
module stb_top_props (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic dma_i,
  input wire logic [3:0] match_ack_i,
  input wire logic wrap_ack_i,
  input wire logic trig_i,
  input wire logic [7:0] rdata_o,
  input wire logic irq_o,
  input wire logic dma_req_o
);
  timeunit 1ns / 1ps;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // Clears assume a stopped counter: a same-cycle wrap wins over the clear
  property p_read_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
  a_read_idle: assert property (p_read_idle)
    else $error("read data not zero outside a read");
  property p_flag_held; dma_req_o && !wr_i && !$past(wr_i) |=> dma_req_o; endproperty
  a_flag_held: assert property (p_flag_held)
    else $error("wrap request dropped without a write");
  property p_clear_one;
    wr_i && addr_i == `STB_ADR_FLAGS && wdata_i[0] |-> ##[1:3] !dma_req_o;
  endproperty
  a_clear_one: assert property (p_clear_one)
    else $error("wrap flag not cleared by writing one");
  property p_dma_clear;
    wr_i && dma_i && (addr_i == 8'h20 || addr_i == 8'h26 || addr_i == 8'h37)
      |-> ##[1:3] !dma_req_o;
  endproperty
  a_dma_clear: assert property (p_dma_clear)
    else $error("transfer write did not withdraw request");
  property p_buf_rw;
    wr_i && (addr_i == 8'h37 || addr_i == 8'h38 || addr_i == 8'h39)
      ##2 rd_i && addr_i == $past(addr_i, 2) |=> rdata_o == $past(wdata_i, 3);
  endproperty
  a_buf_rw: assert property (p_buf_rw)
    else $error("buffer byte read back differs");
  property p_bv_set;
    wr_i && addr_i == 8'h37 ##2 rd_i && addr_i == `STB_ADR_BV_CLR |=> rdata_o[0];
  endproperty
  a_bv_set: assert property (p_bv_set)
    else $error("period buffer valid not set");
  property p_cmd_zero; rd_i && addr_i == `STB_ADR_CTRLG_SET |=> rdata_o[7:2] == 6'h00; endproperty
  a_cmd_zero: assert property (p_cmd_zero)
    else $error("command bits not read as zero");
  property p_unmapped; rd_i && addr_i == 8'h10 |=> rdata_o == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule // stb_top_props

bind stb_top stb_top_props stb_top_props_i (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .dma_i(dma_i), .match_ack_i(match_ack_i),
  .wrap_ack_i(wrap_ack_i), .trig_i(trig_i), .rdata_o(rdata_o), .irq_o(irq_o),
  .dma_req_o(dma_req_o));
`default_nettype wire

// [test_stb_top.sv]
// Self-checking bench for the split byte timer register block
`include "stb_regs.vh"
`default_nettype none
module test_stb_top;
  timeunit 1ns / 1ps;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic dma_i = 1'b0;
  logic [3:0] match_ack_i = 4'h0;
  logic wrap_ack_i = 1'b0;
  logic trig_i = 1'b0;
  wire [7:0] rdata_o;
  wire irq_o;
  wire dma_req_o;
  int bad_count = 0;
  int samples_checked = 0;
  logic [7:0] q;
  // Address, written value, expected read back
  logic [23:0] rows [12] = '{24'h205a5a, 24'h26c3c3, 24'h376666, 24'h281111, 24'h2e1e1e,
    24'h292121, 24'h2f2f2f, 24'h381818, 24'h3e3e3e, 24'h399393, 24'h3ff3f3, 24'h10aa00};
  logic [2:0] modes [4] = '{3'h0, `STB_WG_DS_BOT, `STB_WG_DS_TOP, 3'h7};
  logic [7:0] dadr [3] = '{`STB_ADR_LOW_COUNT_BYTE, `STB_ADR_LOW_PERIOD_BYTE, `STB_ADR_LOW_PERIOD_BUFFER_BYTE};

  stb_top stb_top_i (.clk_i(clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .dma_i(dma_i), .match_ack_i(match_ack_i),
    .wrap_ack_i(wrap_ack_i), .trig_i(trig_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .dma_req_o(dma_req_o));

  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic dm);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    dma_i <= dm;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    dma_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    q = rdata_o;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wait_req(input logic lvl);
    for (int n = 0; n < 40 && dma_req_o !== lvl; n++) begin
      @(posedge clk_i);
      #1;
    end
  endtask
  // Run until the wrap flag rises, then stop so later clears cannot race a wrap
  task automatic wrap(input logic [2:0] mode);
    wr(`STB_ADR_CTRL, {5'h01, mode}, 1'b0);
    wait_req(1'b1);
    wr(`STB_ADR_CTRL, {5'h00, mode}, 1'b0);
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    end_of_test;
  end

  initial begin
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    foreach (rows[i]) begin
      rd(rows[i][23:16]);
      chk(q, 8'h00);
      wr(rows[i][23:16], rows[i][15:8], 1'b0);
      rd(rows[i][23:16]);
      chk(q, rows[i][7:0]);
    end
    wr(`STB_ADR_CTRLG_SET, 8'h02, 1'b0);
    rd(`STB_ADR_CTRLG_SET);
    chk(q, 8'h02);
    wr(`STB_ADR_LOW_PERIOD_BUFFER_BYTE, 8'h77, 1'b0);
    rd(`STB_ADR_BV_CLR);
    chk(q, 8'h13);
    wr(`STB_ADR_CTRLG_SET, {4'h0, `STB_CMD_UPDATE, 2'h0}, 1'b0);
    rd(`STB_ADR_LOW_PERIOD_BYTE);
    chk(q, 8'hc3);
    wr(`STB_ADR_CTRLG_CLR, 8'h02, 1'b0);
    wr(`STB_ADR_CTRLG_SET, {4'h0, `STB_CMD_UPDATE, 2'h0}, 1'b0);
    rd(`STB_ADR_LOW_PERIOD_BYTE);
    chk(q, 8'h77);
    rd(`STB_ADR_LCC_BASE);
    chk(q, 8'h18);
    rd(`STB_ADR_BV_CLR);
    chk(q, 8'h00);
    wr(`STB_ADR_LOW_PERIOD_BYTE, 8'h03, 1'b0);
    wr(`STB_ADR_LOW_COUNT_BYTE, 8'h00, 1'b0);
    wr(`STB_ADR_LCC_BASE, 8'h02, 1'b0);
    wr(`STB_ADR_IRQ_EN, 8'h11, 1'b0);
    foreach (modes[i]) begin
      wrap(modes[i]);
      chk({7'h00, dma_req_o}, 8'h01);
      wr(`STB_ADR_FLAGS, 8'h01, 1'b0);
      wait_req(1'b0);
      chk({7'h00, dma_req_o}, 8'h00);
    end
    wrap(3'h0);
    chk({7'h00, irq_o}, 8'h01);
    rd(`STB_ADR_FLAGS);
    chk(q, 8'h71);
    @(posedge clk_i);
    wrap_ack_i <= 1'b1;
    match_ack_i <= 4'h7;
    @(posedge clk_i);
    wrap_ack_i <= 1'b0;
    match_ack_i <= 4'h0;
    rd(`STB_ADR_FLAGS);
    chk(q, 8'h01);
    wr(`STB_ADR_FLAGS, 8'h00, 1'b0);
    chk({7'h00, dma_req_o}, 8'h01);
    wr(`STB_ADR_IRQ_EN, 8'h00, 1'b0);
    repeat (2) @(posedge clk_i);
    #1;
    chk({7'h00, irq_o}, 8'h00);
    foreach (dadr[i]) begin
      if (i > 0) wrap(3'h0);
      wr(dadr[i], 8'h03, 1'b1);
      wait_req(1'b0);
      chk({7'h00, dma_req_o}, 8'h00);
    end
    @(posedge clk_i);
    srst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    srst_i <= 1'b0;
    rd(`STB_ADR_LOW_PERIOD_BYTE);
    chk(q, 8'h00);
    end_of_test;
  end
endmodule // test_stb_top
`default_nettype wire
